// ==== shared/mic_defines.svh ====
`ifndef MIC_DEFINES_SVH
`define MIC_DEFINES_SVH
// register byte addresses (printed offsets are not all multiples of four)
`define MIC_IDX_FLASH 8'h41
`define MIC_IDX_TIMC 8'h47
`define MIC_IDX_SER 8'h4F
`define MIC_IDX_PIN1 8'h59
`define MIC_IDX_PIN3 8'h5A
`define MIC_IDX_PIN0 8'h5D
`define MIC_ADDR_FLASH 12'h104
`define MIC_ADDR_TIMC 12'h11C
`define MIC_ADDR_SER 12'h13C
`define MIC_ADDR_PIN1 12'h164
`define MIC_ADDR_PIN3 12'h168
`define MIC_ADDR_PIN0 12'h174
`define MIC_ADDR_CPU 12'h200
`define MIC_ADDR_SSEL 12'h204
`define MIC_ADDR_EDGE 12'h208
`define MIC_ADDR_STAT 12'h20C
// fields
`define MIC_LVL_LSB 0
`define MIC_LVL_MSB 2
`define MIC_REQ_BIT 3
`define MIC_POL_BIT 4
`define MIC_RSV_BIT 5
`define MIC_FLG_I 6
`define MIC_FLG_D 3
`define MIC_FLG_U 7
`define MIC_LVL_OFF 3'h0
`define MIC_LVL_MAX 3'h7
`define MIC_SRC_NUM 6
`define MIC_SEQ_CYCLES 5'h14
`define MIC_INFO_ADDR 20'h00000
`define MIC_SWI_HI_LSB 5
`define MIC_RESP_OKAY 2'h0
`define MIC_RESP_SLVERR 2'h2
`define MIC_ZERO8 8'h00
`endif

// ==== shared/mic_pkg.sv ====
package mic_pkg;
    typedef enum logic [6:0] {
        MIC_IDLE = 7'h01,
        MIC_INFO = 7'h02,
        MIC_FLAG = 7'h04,
        MIC_PUSH = 7'h08,
        MIC_IPL = 7'h10,
        MIC_VEC = 7'h20,
        MIC_WAIT = 7'h40
    } mic_state_t;
    typedef enum logic [1:0] {
        MIC_SRC_MASK = 2'h0,
        MIC_SRC_SPEC = 2'h1,
        MIC_SRC_SOFT = 2'h2
    } mic_kind_t;
endpackage : mic_pkg

// ==== core/mic_edge_det.sv ====
`timescale 1ns/100ps
`include "mic_defines.svh"
module mic_edge_det
    import mic_pkg::*;
(
    // clock
    input wire logic aclk,
    input wire logic aresetn,
    // pin and mode
    input wire logic pin,
    input wire logic edge_polarity,
    input wire logic both,
    output logic hit
);
    logic s1_ff, s2_ff, s3_ff;
    logic nxt_s3;
    logic pol_ff;
    always_comb begin
        nxt_s3 = s2_ff;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
            pol_ff <= 1'b0;
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= nxt_s3;
            pol_ff <= edge_polarity;
        end
    end
    // polarity flip seen as an edge on purpose: mirrors the silicon hazard
    logic lvl_now, lvl_old;
    assign lvl_now = edge_polarity ? s2_ff : ~s2_ff;
    assign lvl_old = pol_ff ? s3_ff : ~s3_ff;
    always_comb begin
        if (both) begin
            hit = s2_ff ^ s3_ff;
        end else begin
            hit = lvl_now & ~lvl_old; // R3 R5
        end
    end
endmodule : mic_edge_det

// ==== core/mic_regfile.sv ====
`timescale 1ns/100ps
`include "mic_defines.svh"
module mic_regfile
    import mic_pkg::*;
(
    // clock
    input wire logic aclk,
    input wire logic aresetn,
    // write side
    input wire logic we,
    input wire logic [2:0] widx,
    input wire logic [7:0] wdata,
    // hardware request set and acceptance clear
    input wire logic [5:0] set_req,
    input wire logic [5:0] clr_req,
    // read side
    input wire logic [2:0] ridx,
    output logic [7:0] rdata,
    output logic [5:0][7:0] regs
);
    logic [5:0][7:0] reg_ff, nxt_reg;
    logic [7:0] rdata_ff, nxt_rdata;
    assign regs = reg_ff;
    assign rdata = rdata_ff;
    genvar g;
    generate
        for (g = 0; g < `MIC_SRC_NUM; g++) begin : g_src
            always_comb begin
                nxt_reg[g] = reg_ff[g];
                if (we && widx == 3'(g)) begin
                    nxt_reg[g][`MIC_LVL_MSB:`MIC_LVL_LSB] = wdata[`MIC_LVL_MSB:`MIC_LVL_LSB]; // R1
                    if (g >= 3) begin
                        nxt_reg[g][`MIC_POL_BIT] = wdata[`MIC_POL_BIT];
                        nxt_reg[g][`MIC_RSV_BIT] = wdata[`MIC_RSV_BIT];
                        // only a clear is honoured
                        if (!wdata[`MIC_REQ_BIT]) begin
                            nxt_reg[g][`MIC_REQ_BIT] = 1'b0; // R2
                        end
                    end
                end
                if (clr_req[g]) begin
                    nxt_reg[g][`MIC_REQ_BIT] = 1'b0; // R8
                end
                // set beats any clear in the same cycle
                if (set_req[g]) begin
                    nxt_reg[g][`MIC_REQ_BIT] = 1'b1; // R8
                end
            end
        end
    endgenerate
    always_comb begin
        nxt_rdata = (ridx < 3'(`MIC_SRC_NUM)) ? reg_ff[ridx] : `MIC_ZERO8;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_ff <= '0;
            rdata_ff <= `MIC_ZERO8;
        end else begin
            reg_ff <= nxt_reg;
            rdata_ff <= nxt_rdata;
        end
    end
endmodule : mic_regfile

// ==== core/mic_ctrl.sv ====
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "mic_defines.svh"
// Behaviour
// [R1] control register bits 0-2 hold level; 000 disables, 7 highest
// [R2] software may only clear the request flag by writing 0; code clears it only for pin sources 3-5, not 0-2
// [R3] edge polarity bit 4: 0 falling edge, 1 rising edge
// [R4] software keeps polarity 0 when both-edge detection is chosen
// [R5] changing polarity may set the request flag
// [R6] software rewrites control only while its source is quiet
// [R7] global enable flag 1 allows maskable interrupts, 0 blocks all
// [R8] request flag set on request, cleared when accepted and vectored
// [R9] accept needs enable 1, request 1, level above processor level
// [R10] processor level passes only higher levels; 111 blocks all
// [R11] enable, request, level and processor level are independent storage
// [R12] request checked at instruction end; sequence starts next cycle
// [R13] string move, string store, multiply-accumulate get suspended immediately
// [R14] sequence reads address 00000h and clears accepted request flag
// [R15] flags copied, then I, D, U cleared; U kept for soft 32-63
// [R16] push flags and PC, load processor level, load PC from vector
// [R17] entry sequence lasts 20 cycles
// [R18] special sources set processor level 7; soft ones leave it
// [R19] first word: PC high 4, level 4, flags low 8; then PC low
// [R20] saving done as four byte-wide stack writes
// [R21] serial control register serves unit chosen by a select bit
// [R22] equal levels resolved by fixed hardware order
module mic_ctrl
    import mic_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // request sources
    input wire logic flash_req,
    input wire logic timer_c_req,
    input wire logic serial_ssu_req,
    input wire logic serial_iic_req,
    input wire logic [2:0] ext_pin,
    // cpu side
    input wire logic insn_done,
    input wire logic insn_suspendable,
    input wire logic special_req,
    input wire logic special_sets_ipl,
    input wire logic soft_req,
    input wire logic [5:0] soft_num,
    input wire logic [7:0] cpu_flags,
    input wire logic [19:0] cpu_pc,
    input wire logic [19:0] vector_pc,
    input wire logic stack_ready,
    // cpu outputs
    output logic seq_busy,
    output logic info_rd,
    output logic [19:0] info_addr,
    output logic [2:0] ack_src,
    output logic stack_we,
    output logic [7:0] stack_byte,
    output logic [1:0] stack_step,
    output logic [7:0] new_flags,
    output logic pc_load,
    output logic [19:0] new_pc
);
    // ==================================================================
    // cpu flag/level storage
    // ==================================================================
    // software writes: flags byte 0, ipl bits 10:8; independent fields
    logic [7:0] flg_ff, nxt_flg, tmp_ff, nxt_tmp;
    logic [2:0] ipl_ff, nxt_ipl, lvl_ff, nxt_lvl;
    logic ssel_ff, nxt_ssel;
    logic [2:0] both_ff, nxt_both;
    mic_state_t st_ff, nxt_st;
    mic_kind_t kind_ff, nxt_kind;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [1:0] byte_ff, nxt_byte;

    // ==================================================================
    // bus slave
    // ==================================================================
    logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
    logic [11:0] awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
    logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
    logic ar_pend_ff, nxt_ar_pend;
    logic [11:0] ara_ff, nxt_ara;
    logic do_wr;
    logic [2:0] widx, ridx;
    logic [7:0] rf_rdata;
    logic [5:0][7:0] regs;
    logic [5:0] set_req, clr_req;

    function automatic logic [2:0] map_idx(input logic [11:0] a);
        case (a)
            `MIC_ADDR_FLASH: map_idx = 3'h0;
            `MIC_ADDR_TIMC: map_idx = 3'h1;
            `MIC_ADDR_SER: map_idx = 3'h2;
            `MIC_ADDR_PIN1: map_idx = 3'h3;
            `MIC_ADDR_PIN3: map_idx = 3'h4;
            `MIC_ADDR_PIN0: map_idx = 3'h5;
            default: map_idx = 3'h7;
        endcase
    endfunction : map_idx

    function automatic logic known(input logic [11:0] a);
        known = (map_idx(a) != 3'h7) || a == `MIC_ADDR_CPU || a == `MIC_ADDR_SSEL
            || a == `MIC_ADDR_EDGE || a == `MIC_ADDR_STAT;
    endfunction : known

    assign do_wr = aw_ff && w_ff && !bv_ff;
    assign widx = map_idx(awa_ff);
    assign ridx = map_idx(s_axi_araddr);

    always_comb begin
        nxt_aw = aw_ff;
        nxt_awa = awa_ff;
        nxt_w = w_ff;
        nxt_wd = wd_ff;
        nxt_bv = bv_ff;
        nxt_br = br_ff;
        if (s_axi_awvalid && !aw_ff) begin
            nxt_aw = 1'b1;
            nxt_awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_ff) begin
            nxt_w = 1'b1;
            nxt_wd = s_axi_wdata;
        end
        if (do_wr) begin
            nxt_bv = 1'b1;
            nxt_br = known(awa_ff) ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
        end
        if (bv_ff && s_axi_bready) begin
            nxt_bv = 1'b0;
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
        end
    end

    // read data registered once in regfile; answer two cycles after address
    always_comb begin
        nxt_ar_pend = ar_pend_ff;
        nxt_ara = ara_ff;
        nxt_rv = rv_ff;
        nxt_rd = rd_ff;
        nxt_rr = rr_ff;
        if (s_axi_arvalid && !ar_pend_ff && !rv_ff) begin
            nxt_ar_pend = 1'b1;
            nxt_ara = s_axi_araddr;
        end
        if (ar_pend_ff) begin
            nxt_ar_pend = 1'b0;
            nxt_rv = 1'b1;
            nxt_rr = known(ara_ff) ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
            case (ara_ff)
                `MIC_ADDR_CPU: nxt_rd = {21'h0, ipl_ff, flg_ff};
                `MIC_ADDR_SSEL: nxt_rd = {31'h0, ssel_ff};
                `MIC_ADDR_EDGE: nxt_rd = {29'h0, both_ff};
                `MIC_ADDR_STAT: nxt_rd = {22'h0, byte_ff, ack_src, st_ff == MIC_IDLE ? 1'b0 : 1'b1,
                    cnt_ff[3:0]};
                default: nxt_rd = {24'h0, rf_rdata};
            endcase
        end
        if (rv_ff && s_axi_rready) begin
            nxt_rv = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            awa_ff <= 12'h000;
            w_ff <= 1'b0;
            wd_ff <= 32'h00000000;
            bv_ff <= 1'b0;
            br_ff <= `MIC_RESP_OKAY;
            ar_pend_ff <= 1'b0;
            ara_ff <= 12'h000;
            rv_ff <= 1'b0;
            rd_ff <= 32'h00000000;
            rr_ff <= `MIC_RESP_OKAY;
        end else begin
            aw_ff <= nxt_aw;
            awa_ff <= nxt_awa;
            w_ff <= nxt_w;
            wd_ff <= nxt_wd;
            bv_ff <= nxt_bv;
            br_ff <= nxt_br;
            ar_pend_ff <= nxt_ar_pend;
            ara_ff <= nxt_ara;
            rv_ff <= nxt_rv;
            rd_ff <= nxt_rd;
            rr_ff <= nxt_rr;
        end
    end
    // ready pulses when a channel is first captured
    logic awr_ff, wr_ff, arr_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awr_ff <= 1'b0;
            wr_ff <= 1'b0;
            arr_ff <= 1'b0;
        end else begin
            awr_ff <= s_axi_awvalid && !aw_ff && !awr_ff;
            wr_ff <= s_axi_wvalid && !w_ff && !wr_ff;
            arr_ff <= s_axi_arvalid && !ar_pend_ff && !rv_ff && !arr_ff;
        end
    end
    assign s_axi_awready = awr_ff;
    assign s_axi_wready = wr_ff;
    assign s_axi_arready = arr_ff;
    assign s_axi_bvalid = bv_ff;
    assign s_axi_bresp = br_ff;
    assign s_axi_rvalid = rv_ff;
    assign s_axi_rdata = rd_ff;
    assign s_axi_rresp = rr_ff;

    // ==================================================================
    // request sources
    // ==================================================================
    logic [2:0] pin_hit;
    logic [2:0] pin_pol;
    assign pin_pol = {regs[5][`MIC_POL_BIT], regs[4][`MIC_POL_BIT], regs[3][`MIC_POL_BIT]};
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_pin
            mic_edge_det u_edge (
                .aclk(aclk),
                .aresetn(aresetn),
                .pin(ext_pin[p]),
                .edge_polarity(pin_pol[p]),
                .both(both_ff[p]),
                .hit(pin_hit[p])
            );
        end
    endgenerate
    logic [2:0] per_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            per_ff <= 3'h0;
        end else begin
            per_ff <= {ssel_ff ? serial_iic_req : serial_ssu_req, timer_c_req, flash_req}; // R21
        end
    end
    assign set_req = {pin_hit, per_ff};

    mic_regfile u_rf (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(do_wr && widx != 3'h7),
        .widx(widx),
        .wdata(wd_ff[7:0]),
        .set_req(set_req),
        .clr_req(clr_req),
        .ridx(ridx),
        .rdata(rf_rdata),
        .regs(regs)
    );

    // ==================================================================
    // arbitration
    // ==================================================================
    logic cand_v;
    logic [2:0] cand_src, cand_lvl;
    always_comb begin
        cand_v = 1'b0;
        cand_src = 3'h0;
        cand_lvl = `MIC_LVL_OFF;
        // lower index wins ties: strict greater-than keeps the first
        for (int i = 0; i < `MIC_SRC_NUM; i++) begin
            if (regs[i][`MIC_REQ_BIT] && regs[i][`MIC_LVL_MSB:`MIC_LVL_LSB] > ipl_ff // R9 R10
                && regs[i][`MIC_LVL_MSB:`MIC_LVL_LSB] > cand_lvl) begin // R1 R22
                cand_v = 1'b1;
                cand_src = 3'(i);
                cand_lvl = regs[i][`MIC_LVL_MSB:`MIC_LVL_LSB];
            end
        end
        cand_v = cand_v && flg_ff[`MIC_FLG_I]; // R7
    end
    logic take;
    assign take = (insn_done || insn_suspendable) // R12 R13
        && (special_req || soft_req || cand_v);

    // ==================================================================
    // entry sequencer
    // ==================================================================
    logic [15:0] push_hi, push_lo;
    assign push_hi = {cpu_pc[19:16], 1'b0, ipl_ff, tmp_ff}; // R19
    assign push_lo = cpu_pc[15:0];
    logic [7:0] push_b;
    always_comb begin
        case (byte_ff)
            2'h0: push_b = push_hi[15:8];
            2'h1: push_b = push_hi[7:0];
            2'h2: push_b = push_lo[15:8];
            default: push_b = push_lo[7:0];
        endcase
    end

    logic o_info_ff, o_we_ff, o_pcl_ff;
    logic [2:0] o_src_ff;
    logic [19:0] o_pc_ff;
    logic [7:0] o_byte_ff;
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff + 5'h1;
        nxt_kind = kind_ff;
        nxt_lvl = lvl_ff;
        nxt_tmp = tmp_ff;
        nxt_flg = flg_ff;
        nxt_ipl = ipl_ff;
        nxt_byte = byte_ff;
        nxt_ssel = ssel_ff;
        nxt_both = both_ff;
        clr_req = 6'h0;
        if (do_wr && awa_ff == `MIC_ADDR_CPU) begin
            nxt_flg = wd_ff[7:0]; // R11
            nxt_ipl = wd_ff[10:8];
        end
        if (do_wr && awa_ff == `MIC_ADDR_SSEL) begin
            nxt_ssel = wd_ff[0];
        end
        if (do_wr && awa_ff == `MIC_ADDR_EDGE) begin
            nxt_both = wd_ff[2:0];
        end
        case (st_ff)
            MIC_IDLE: begin
                nxt_cnt = 5'h0;
                if (take) begin
                    nxt_st = MIC_INFO; // R12
                    nxt_kind = special_req ? MIC_SRC_SPEC : soft_req ? MIC_SRC_SOFT : MIC_SRC_MASK;
                    nxt_lvl = special_req ? `MIC_LVL_MAX : cand_lvl;
                    nxt_tmp = cpu_flags; // R15
                    if (!special_req && !soft_req) begin
                        clr_req[cand_src] = 1'b1; // R14 R8
                    end
                end
            end
            MIC_INFO: nxt_st = MIC_FLAG; // R14
            MIC_FLAG: begin
                nxt_flg = tmp_ff;
                nxt_flg[`MIC_FLG_I] = 1'b0; // R15
                nxt_flg[`MIC_FLG_D] = 1'b0;
                if (!(kind_ff == MIC_SRC_SOFT && soft_num[`MIC_SWI_HI_LSB])) begin
                    nxt_flg[`MIC_FLG_U] = 1'b0;
                end
                nxt_byte = 2'h0;
                nxt_st = MIC_PUSH;
            end
            MIC_PUSH: begin
                if (stack_ready) begin
                    nxt_byte = byte_ff + 2'h1; // R20
                    if (byte_ff == 2'h3) begin
                        nxt_st = MIC_IPL; // R16
                    end
                end
            end
            MIC_IPL: begin
                if (kind_ff == MIC_SRC_MASK || (kind_ff == MIC_SRC_SPEC && special_sets_ipl)) begin
                    nxt_ipl = lvl_ff; // R16 R18
                end
                nxt_st = MIC_VEC;
            end
            MIC_VEC: nxt_st = MIC_WAIT; // R16
            MIC_WAIT: begin
                if (cnt_ff >= `MIC_SEQ_CYCLES - 5'h1) begin
                    nxt_st = MIC_IDLE; // R17
                end
            end
            default: nxt_st = MIC_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= MIC_IDLE;
            cnt_ff <= 5'h0;
            kind_ff <= MIC_SRC_MASK;
            lvl_ff <= `MIC_LVL_OFF;
            tmp_ff <= `MIC_ZERO8;
            flg_ff <= `MIC_ZERO8;
            ipl_ff <= `MIC_LVL_OFF;
            byte_ff <= 2'h0;
            ssel_ff <= 1'b0;
            both_ff <= 3'h0;
            o_info_ff <= 1'b0;
            o_src_ff <= 3'h0;
            o_we_ff <= 1'b0;
            o_byte_ff <= `MIC_ZERO8;
            o_pcl_ff <= 1'b0;
            o_pc_ff <= `MIC_INFO_ADDR;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            kind_ff <= nxt_kind;
            lvl_ff <= nxt_lvl;
            tmp_ff <= nxt_tmp;
            flg_ff <= nxt_flg;
            ipl_ff <= nxt_ipl;
            byte_ff <= nxt_byte;
            ssel_ff <= nxt_ssel;
            both_ff <= nxt_both;
            o_info_ff <= nxt_st == MIC_INFO;
            if (st_ff == MIC_IDLE && take) begin
                o_src_ff <= cand_src;
            end
            o_we_ff <= st_ff == MIC_PUSH && stack_ready;
            o_byte_ff <= push_b;
            o_pcl_ff <= st_ff == MIC_VEC;
            o_pc_ff <= vector_pc;
        end
    end
    assign seq_busy = st_ff != MIC_IDLE;
    assign info_rd = o_info_ff;
    assign info_addr = `MIC_INFO_ADDR;
    assign ack_src = o_src_ff;
    assign stack_we = o_we_ff;
    assign stack_byte = o_byte_ff;
    assign stack_step = byte_ff;
    assign new_flags = flg_ff;
    assign pc_load = o_pcl_ff;
    assign new_pc = o_pc_ff;

    // ==================================================================
    // checks
    // ==================================================================
    a_seq_len: assert property (@(posedge aclk) disable iff (!aresetn) // R17
        $rose(seq_busy) |-> seq_busy [*8])
        else $error("entry sequence ended early");
    a_ipl_block: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        ipl_ff == `MIC_LVL_MAX |-> !cand_v)
        else $error("maskable passed at top level");
    a_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        !flg_ff[`MIC_FLG_I] |-> !cand_v)
        else $error("maskable passed with enable clear");
    a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R15
        st_ff == MIC_FLAG |=> !flg_ff[`MIC_FLG_I] && !flg_ff[`MIC_FLG_D])
        else $error("flags not cleared");
    a_push_four: assert property (@(posedge aclk) disable iff (!aresetn) // R20
        st_ff == MIC_IPL |-> $past(byte_ff) == 2'h3)
        else $error("push count wrong");
    a_ipl_load: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        st_ff == MIC_IPL && kind_ff == MIC_SRC_MASK |=> ipl_ff == lvl_ff)
        else $error("level not loaded");
    a_req_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R14
        st_ff == MIC_IDLE && take && !special_req && !soft_req && !set_req[cand_src]
        |=> !regs[$past(cand_src)][`MIC_REQ_BIT])
        else $error("request not cleared");
    a_info_first: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        st_ff == MIC_IDLE && take |=> st_ff == MIC_INFO)
        else $error("sequence did not start");
    c_mask: cover property (@(posedge aclk) st_ff == MIC_IDLE && take && cand_v);
    c_spec: cover property (@(posedge aclk) st_ff == MIC_IDLE && take && special_req);
    c_push: cover property (@(posedge aclk) st_ff == MIC_PUSH && byte_ff == 2'h3);
endmodule : mic_ctrl

// ==== testbench/mic_cpu_model.sv ====
`timescale 1ns/100ps
// ==========
// cpu side: instruction end and stack handshake
module mic_cpu_model (
    // clock
    input wire logic aclk,
    input wire logic aresetn,
    // bench control
    input wire logic slow,
    input wire logic go,
    // to controller
    output logic insn_done,
    output logic stack_ready
);
    logic ph_ff;
    // slow mode stalls the stack every other cycle
    always_ff @(posedge aclk) begin
        ph_ff <= aresetn ? ~ph_ff : 1'b0;
        insn_done <= aresetn & go;
    end
    assign stack_ready = ~slow | ph_ff;
endmodule : mic_cpu_model

// ==== testbench/tb_maskable_interrupt_control.sv ====
`timescale 1ns/100ps
`include "mic_defines.svh"
module tb_maskable_interrupt_control;
    logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, go = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv, sd = 32'h431B;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, stack_step;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic flash_req = '0, timer_c_req = '0, serial_ssu_req = '0, serial_iic_req = '0;
    logic insn_suspendable = '0, special_req = '0, special_sets_ipl = '0, soft_req = '0;
    logic [2:0] ext_pin = 3'h7, ack_src;
    logic [5:0] soft_num = '0;
    logic [7:0] cpu_flags = 8'hFF, stack_byte, new_flags, q[$];
    logic [19:0] cpu_pc = '0, vector_pc = '0, info_addr, new_pc;
    logic insn_done, stack_ready, seq_busy, info_rd, stack_we, pc_load;
    int bad_count = 0, checks = 0, cyc, lvl;
    always #2 aclk = ~aclk;
    mic_ctrl DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_req, .timer_c_req,
        .serial_ssu_req, .serial_iic_req, .ext_pin, .insn_done, .insn_suspendable,
        .special_req, .special_sets_ipl, .soft_req, .soft_num, .cpu_flags, .cpu_pc,
        .vector_pc, .stack_ready, .seq_busy, .info_rd, .info_addr, .ack_src, .stack_we,
        .stack_byte, .stack_step, .new_flags, .pc_load, .new_pc);
    mic_cpu_model cpu (.aclk, .aresetn, .slow, .go, .insn_done, .stack_ready);
    // ==========
    // reference capture
    always @(posedge aclk) begin
        if (stack_we === 1'b1) q.push_back(stack_byte);
        if (seq_busy === 1'b1) cyc++;
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task end_sim;
        if (bad_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    // ==========
    // bus master
    task wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n++ < 60);
        if (n > 60) bad_count++;
        s_axi_bready <= 1'b0;
    endtask : wr
    task rd(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n++ < 60);
        if (n > 60) bad_count++;
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    // refusal runs the full bound with cyc left at zero
    task kick(input logic susp);
        int n;
        n = 0;
        q = {};
        cyc = 0;
        @(posedge aclk);
        if (susp) insn_suspendable <= 1'b1;
        else go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        do @(posedge aclk); while ((cyc == 0 || seq_busy === 1'b1) && n++ < 60);
        insn_suspendable <= 1'b0;
    endtask : kick
    initial begin
        #40000;
        bad_count++;
        end_sim;
    end
    // ==========
    // scenarios
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`MIC_ADDR_FLASH);
        chk("lvl_reset", rv[2:0], 0);
        rd(12'h0F0);
        chk("unmapped", rs, `MIC_RESP_SLVERR);
        wr(`MIC_ADDR_PIN0, 8'h15);
        rd(`MIC_ADDR_PIN0);
        chk("pin0", {rv[4], rv[3:0]}, 5'h1D);
        wr(`MIC_ADDR_PIN0, 8'h15);
        for (int k = 0; k < 2; k++) begin
            sd = nx(sd);
            lvl = 1 + sd % 7;
            cpu_pc <= sd[19:0];
            cpu_flags <= sd[31:24];
            vector_pc <= sd[27:8];
            soft_num <= sd[5:0];
            slow <= k[0];
            wr(`MIC_ADDR_FLASH, lvl);
            wr(`MIC_ADDR_TIMC, lvl);
            wr(`MIC_ADDR_CPU, 32'h40);
            flash_req <= 1'b1;
            timer_c_req <= 1'b1;
            @(posedge aclk);
            flash_req <= 1'b0;
            timer_c_req <= 1'b0;
            rd(`MIC_ADDR_FLASH);
            chk("req_set", rv[3], 1);
            kick(k[0]);
            chk("src", ack_src, 0);
            chk("bytes", q.size(), 4);
            chk("pc_hi", q[0], {cpu_pc[19:16], 4'h0});
            chk("flg_push", q[1], cpu_flags);
            chk("pc_lo", {q[2], q[3]}, cpu_pc[15:0]);
            if (k == 0) chk("len", cyc, 20);
            chk("flags", new_flags & 8'hC8, 0);
            chk("new_pc", new_pc, vector_pc);
            rd(`MIC_ADDR_FLASH);
            chk("req_clr", rv[3:0], lvl);
            rd(`MIC_ADDR_CPU);
            chk("ipl", rv[10:8], lvl);
            wr(`MIC_ADDR_CPU, 32'h0);
            kick(1'b0);
            chk("i_off", cyc, 0);
            wr(`MIC_ADDR_CPU, 32'h40 | (lvl << 8));
            kick(1'b0);
            chk("ipl_eq", cyc, 0);
        end
        end_sim;
    end
endmodule : tb_maskable_interrupt_control
